//--- shared/iorm_defs.svh
// What this block does
// - ports A to D sit at addresses 0x00 to 0x03, read and write as port data.
// - reserved addresses 0x04 to 0x0F run as cycles on the external eight-bit data bus.
// - interrupt flag write only clears bits 0 to 3; a zero clears, a one keeps.
// - serial status write changes only bits 4 and 5; other bits ignore it.
// - serial data address reads the received byte and writes the transmit byte.
// - reading 0x18 returns counter A low byte and clears the counter A flag.
// - reading 0x1C returns counter B low byte and clears the counter B flag.
// - writing 0x1E stores upper latch B, loads counter B, clears its flag.
// - short bus mode: C carries A0-A3, A12, read/write, A13, strobe; D carries data.
// - full-address mode drives A13 and A14 on C6 and C7; other C pins stay port pins.
`ifndef IORM_DEFS_SVH
`define IORM_DEFS_SVH

// ==========================================
// register offsets
`define IORM_OFF_PORT_LAST  16'h0003
`define IORM_OFF_RSV_FIRST  16'h0004
`define IORM_OFF_RSV_LAST   16'h000f
`define IORM_OFF_READ_FF0   16'h0010
`define IORM_OFF_INT_FLAGS  16'h0012
`define IORM_OFF_INT_ENA    16'h0013
`define IORM_OFF_MODE       16'h0014
`define IORM_OFF_SER_CTRL   16'h0015
`define IORM_OFF_SER_STAT   16'h0016
`define IORM_OFF_SER_DATA   16'h0017
`define IORM_OFF_CNTA_CLR   16'h0018
`define IORM_OFF_CNTA_UP    16'h001a
`define IORM_OFF_CNTA_LO    16'h001b
`define IORM_OFF_CNTB_CLR   16'h001c
`define IORM_OFF_CNTB_UP    16'h001e
`define IORM_OFF_CNTB_LO    16'h001f
`define IORM_EXT_BASE       16'h0100

// ==========================================
// fields and reset values
`define IORM_MODE_BUS_BIT   5
`define IORM_MODE_MUX_BIT   6
`define IORM_MODE_EXP_BIT   7
`define IORM_STAT_WR_MASK   8'h30
`define IORM_RST_PORT       8'hff
`define IORM_RST_REG        8'h00
`define IORM_READ_FF        8'hff
`define IORM_LATCH_LOWER    2'h0
`define IORM_LATCH_LOAD     2'h2
`define IORM_PHASE_CYC      2

`endif

//--- shared/iorm_pkg.sv
package iorm_pkg;

	// core request: held with bus_req until bus_ready
	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} iorm_req_t;

	// one byte per parallel port, d in the top byte
	typedef struct packed {
		logic [7:0] d;
		logic [7:0] c;
		logic [7:0] b;
		logic [7:0] a;
	} iorm_port_t;

	// latch write towards the counter engines
	typedef struct packed {
		logic       valid;
		logic       unit_b;
		logic       upper;
		logic       load;
		logic [7:0] data;
	} iorm_cnt_cmd_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ADDR = 4'h2,
		ST_DATA = 4'h4,
		ST_DONE = 4'h8
	} iorm_state_t;

endpackage

//--- rtl/iorm_io_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "iorm_defs.svh"

module iorm_io_decode #(
	parameter int PHASE_CYC = `IORM_PHASE_CYC
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic                    bus_req,
	input  wire iorm_pkg::iorm_req_t     bus_cmd,
	output logic                         bus_ready,
	output logic [7:0]                   bus_rdata,
	input  wire iorm_pkg::iorm_port_t    pin_in,
	output iorm_pkg::iorm_port_t         pin_out,
	output iorm_pkg::iorm_port_t         pin_oe,
	input  wire logic [3:0]              edge_evt,
	input  wire logic [3:0]              flag_hi_in,
	input  wire logic [15:0]             cnt_a_val,
	input  wire logic [15:0]             cnt_b_val,
	output iorm_pkg::iorm_cnt_cmd_t      cnt_cmd,
	output logic                         clr_flag_a,
	output logic                         clr_flag_b,
	input  wire logic [7:0]              rx_data,
	input  wire logic [7:0]              ser_status_in,
	output logic                         rx_taken,
	output logic                         tx_load,
	output logic [7:0]                   tx_data,
	output logic [7:0]                   ser_ctrl,
	output logic [7:0]                   mode_ctrl,
	output logic [7:0]                   int_enable,
	output logic [7:0]                   int_flags
);

	// ==========================================
	// decode helpers
	function automatic logic at(input logic [15:0] a, input logic [15:0] off);
		return a == off;
	endfunction

	iorm_pkg::iorm_state_t state_q, state_d;
	logic [7:0]       cnt_q;
	logic [3:0][7:0]  port_q;
	logic [3:0]       flag_lo_q;
	logic [7:0]       ena_q, mode_q, sctl_q, rdata_q, wdata_q;
	logic [1:0]       stat45_q;
	logic [15:0]      addr_q;
	logic             we_q;
	logic [31:0]      s1_q, s2_q, s3_q, stab_q;
	logic             tx_load_q, rx_taken_q, clr_a_q, clr_b_q;
	iorm_pkg::iorm_cnt_cmd_t cmd_q;

	wire logic [15:0] a      = bus_cmd.addr;
	wire logic        take   = (state_q == iorm_pkg::ST_IDLE) && bus_req;
	wire logic        wr     = take && bus_cmd.we;
	wire logic        rd     = take && !bus_cmd.we;
	wire logic        is_rsv = (a >= `IORM_OFF_RSV_FIRST) && (a <= `IORM_OFF_RSV_LAST);
	wire logic        is_ext = is_rsv || (a >= `IORM_EXT_BASE);
	wire logic        exp_on = mode_q[`IORM_MODE_EXP_BIT];
	wire logic        bus_on = exp_on && mode_q[`IORM_MODE_BUS_BIT];
	wire logic        mux_on = bus_on && mode_q[`IORM_MODE_MUX_BIT];
	wire logic        full_on = exp_on && !mode_q[`IORM_MODE_BUS_BIT];
	wire logic        ext_run = take && is_ext && bus_on;
	wire logic        phase_end = (cnt_q == 8'(PHASE_CYC - 1));
	wire logic        is_port = (a <= `IORM_OFF_PORT_LAST);
	wire logic        is_cnt = (a >= `IORM_OFF_CNTA_CLR) && (a <= `IORM_OFF_CNTB_LO);
	wire logic [31:0] agree = ~(s2_q ^ s3_q);
	wire logic [31:0] stab_d = (agree & s2_q) | (~agree & stab_q);
	wire logic [3:0]  flag_clr = (wr && at(a, `IORM_OFF_INT_FLAGS)) ?
		~bus_cmd.wdata[3:0] : 4'h0;
	wire logic        rd_clr_a = rd && at(a, `IORM_OFF_CNTA_CLR);
	wire logic        rd_clr_b = rd && at(a, `IORM_OFF_CNTB_CLR);
	wire logic        wr_ld_a = wr && at(a, `IORM_OFF_CNTA_UP);
	wire logic        wr_ld_b = wr && at(a, `IORM_OFF_CNTB_UP);

	// ==========================================
	// internal read selection
	logic [7:0] rd_int;
	always_comb begin
		rd_int = `IORM_READ_FF;
		if (is_port) begin
			rd_int = stab_q[{a[1:0], 3'h0} +: 8];
		end
		else begin
			case (a)
				`IORM_OFF_INT_FLAGS: rd_int = {flag_hi_in, flag_lo_q};
				`IORM_OFF_INT_ENA:   rd_int = ena_q;
				`IORM_OFF_MODE:      rd_int = mode_q;
				`IORM_OFF_SER_CTRL:  rd_int = sctl_q;
				`IORM_OFF_SER_STAT:  rd_int = {ser_status_in[7:6], stat45_q, ser_status_in[3:0]};
				`IORM_OFF_SER_DATA:  rd_int = rx_data;
				`IORM_OFF_CNTA_CLR:  rd_int = cnt_a_val[7:0];
				`IORM_OFF_CNTA_UP:   rd_int = cnt_a_val[15:8];
				`IORM_OFF_CNTA_LO:   rd_int = cnt_a_val[7:0];
				`IORM_OFF_CNTB_CLR:  rd_int = cnt_b_val[7:0];
				`IORM_OFF_CNTB_UP:   rd_int = cnt_b_val[15:8];
				`IORM_OFF_CNTB_LO:   rd_int = cnt_b_val[7:0];
				default:             rd_int = `IORM_READ_FF;
			endcase
		end
	end

	// ==========================================
	// access sequencer: internal hits finish at once, external ones
	// walk an address phase and a data phase of PHASE_CYC each
	always_comb begin
		state_d = state_q;
		case (state_q)
			iorm_pkg::ST_IDLE: begin
				if (ext_run) begin
					state_d = iorm_pkg::ST_ADDR;
				end
				else if (take) begin
					state_d = iorm_pkg::ST_DONE;
				end
			end
			iorm_pkg::ST_ADDR: begin
				if (phase_end) begin
					state_d = iorm_pkg::ST_DATA;
				end
			end
			iorm_pkg::ST_DATA: begin
				if (phase_end) begin
					state_d = iorm_pkg::ST_DONE;
				end
			end
			iorm_pkg::ST_DONE: state_d = iorm_pkg::ST_IDLE;
			default:           state_d = iorm_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= iorm_pkg::ST_IDLE;
			cnt_q   <= 8'h00;
		end
		else begin
			state_q <= state_d;
			cnt_q   <= (state_d != state_q || phase_end) ? 8'h00 : cnt_q + 8'h01;
		end
	end

	// pin inputs: three stages, a change counts once stages two and three agree;
	// every stage resets to the idle pull-up level, else a false low follows reset
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_q   <= 32'hffff_ffff;
			s2_q   <= 32'hffff_ffff;
			s3_q   <= 32'hffff_ffff;
			stab_q <= 32'hffff_ffff;
		end
		else begin
			s1_q   <= pin_in;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			stab_q <= stab_d;
		end
	end

	// request capture and read data; unserved external reads give 0xff
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			addr_q  <= 16'h0000;
			we_q    <= 1'b0;
			wdata_q <= `IORM_RST_REG;
			rdata_q <= `IORM_RST_REG;
		end
		else if (take) begin
			addr_q  <= a;
			we_q    <= bus_cmd.we;
			wdata_q <= bus_cmd.wdata;
			rdata_q <= is_ext ? `IORM_READ_FF : rd_int;
		end
		else if (state_q == iorm_pkg::ST_DATA && phase_end && !we_q) begin
			rdata_q <= stab_q[31:24]; // external byte sampled at data phase end
		end
	end

	// ==========================================
	// software registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			port_q    <= {4{`IORM_RST_PORT}};
			ena_q     <= `IORM_RST_REG;
			mode_q    <= `IORM_RST_REG;
			sctl_q    <= `IORM_RST_REG;
			stat45_q  <= 2'h0;
			flag_lo_q <= 4'h0;
		end
		else begin
			if (wr && is_port) begin
				port_q[a[1:0]] <= bus_cmd.wdata;
			end
			if (wr && at(a, `IORM_OFF_INT_ENA)) begin
				ena_q <= bus_cmd.wdata;
			end
			if (wr && at(a, `IORM_OFF_MODE)) begin
				mode_q <= bus_cmd.wdata;
			end
			if (wr && at(a, `IORM_OFF_SER_CTRL)) begin
				sctl_q <= bus_cmd.wdata;
			end
			if (wr && at(a, `IORM_OFF_SER_STAT)) begin
				stat45_q <= bus_cmd.wdata[5:4]; // masked by IORM_STAT_WR_MASK
			end
			// a new edge wins over a clear in the same cycle
			flag_lo_q <= (flag_lo_q & ~flag_clr) | edge_evt;
		end
	end

	// ==========================================
	// side-effect strobes towards serial and counter engines
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_load_q  <= 1'b0;
			rx_taken_q <= 1'b0;
			clr_a_q    <= 1'b0;
			clr_b_q    <= 1'b0;
			cmd_q      <= '0;
		end
		else begin
			tx_load_q   <= wr && at(a, `IORM_OFF_SER_DATA);
			rx_taken_q  <= rd && at(a, `IORM_OFF_SER_DATA);
			clr_a_q     <= rd_clr_a || wr_ld_a;
			clr_b_q     <= rd_clr_b || wr_ld_b;
			// the LO location (0x1b, 0x1f) of each unit takes no write; the clr location writes the lower latch
			cmd_q.valid <= wr && is_cnt && !at(a, `IORM_OFF_CNTA_LO)
				&& !at(a, `IORM_OFF_CNTB_LO);
			cmd_q.unit_b <= a[2];
			cmd_q.upper  <= a[1:0] != `IORM_LATCH_LOWER;
			cmd_q.load   <= a[1:0] == `IORM_LATCH_LOAD;
			cmd_q.data   <= bus_cmd.wdata;
		end
	end

	// ==========================================
	// port C and D pin functions by mode
	wire logic in_cyc  = (state_q == iorm_pkg::ST_ADDR) || (state_q == iorm_pkg::ST_DATA);
	wire logic strobe  = (state_q == iorm_pkg::ST_DATA);
	wire logic [7:0] c_bus = {strobe, addr_q[13], ~(in_cyc && we_q), addr_q[12],
		addr_q[3:0]};
	wire logic [7:0] c_full = {addr_q[14], addr_q[13], port_q[2][5:0]};
	wire logic d_addr = mux_on && (state_q == iorm_pkg::ST_ADDR);
	wire logic d_wr   = strobe && we_q;

	// ports A and B, and C with the expansion bit clear, pull low only; their high comes from the pull-up
	assign pin_out.a = port_q[0];
	assign pin_oe.a  = ~port_q[0];
	assign pin_out.b = port_q[1];
	assign pin_oe.b  = ~port_q[1];
	assign pin_out.c = bus_on ? c_bus : (full_on ? c_full : port_q[2]);
	assign pin_oe.c  = bus_on ? 8'hff : (full_on ? {2'h3, ~port_q[2][5:0]} : ~port_q[2]);
	assign pin_out.d = bus_on ? (d_addr ? addr_q[11:4] : wdata_q) : port_q[3];
	assign pin_oe.d  = bus_on ? {8{d_addr || d_wr}} : 8'hff;

	assign bus_ready  = (state_q == iorm_pkg::ST_DONE);
	assign bus_rdata  = rdata_q;
	assign cnt_cmd    = cmd_q;
	assign clr_flag_a = clr_a_q;
	assign clr_flag_b = clr_b_q;
	assign rx_taken   = rx_taken_q;
	assign tx_load    = tx_load_q;
	assign tx_data    = wdata_q;
	assign ser_ctrl   = sctl_q;
	assign mode_ctrl  = mode_q;
	assign int_enable = ena_q;
	assign int_flags  = {flag_hi_in, flag_lo_q};

endmodule

`default_nettype wire

//--- verification/iorm_io_decode_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port-level checks of the register page
module iorm_io_decode_properties #(
	parameter int PHASE_CYC = 2
) (
	input wire logic                    ref_clk,
	input wire logic                    rst_n,
	input wire logic                    bus_req,
	input wire iorm_pkg::iorm_req_t     bus_cmd,
	input wire logic                    bus_ready,
	input wire logic [7:0]              bus_rdata,
	input wire iorm_pkg::iorm_port_t    pin_out,
	input wire iorm_pkg::iorm_port_t    pin_oe,
	input wire logic [3:0]              edge_evt,
	input wire logic [15:0]             cnt_a_val,
	input wire logic [15:0]             cnt_b_val,
	input wire iorm_pkg::iorm_cnt_cmd_t cnt_cmd,
	input wire logic                    clr_flag_a,
	input wire logic                    clr_flag_b,
	input wire logic [7:0]              ser_status_in,
	input wire logic                    tx_load,
	input wire logic [7:0]              tx_data,
	input wire logic [7:0]              mode_ctrl,
	input wire logic [7:0]              int_flags
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// ==========================================
	// internal transfers: ready comes one cycle after the take
	property p_port;
		bus_ready && $past(bus_req && bus_cmd.we && bus_cmd.addr == 16'h0000)
			|-> pin_oe.a == ~$past(bus_cmd.wdata);
	endproperty
	a_port: assert property (p_port) else $error("port a write lost");
	// a pulse on edge_evt may set a bit in the same cycle, so mask it out
	property p_flag;
		bus_ready && $past(bus_req && bus_cmd.we && bus_cmd.addr == 16'h0012)
			|-> (int_flags[3:0] & ~$past(edge_evt)) ==
			($past(int_flags[3:0]) & $past(bus_cmd.wdata[3:0]) & ~$past(edge_evt));
	endproperty
	a_flag: assert property (p_flag) else $error("flag clear wrong");
	property p_stat;
		bus_ready && $past(bus_req && !bus_cmd.we && bus_cmd.addr == 16'h0016)
			|-> (bus_rdata & 8'hcf) == ($past(ser_status_in) & 8'hcf);
	endproperty
	a_stat: assert property (p_stat) else $error("status bits wrong");
	property p_tx;
		tx_load |-> bus_ready && $past(bus_cmd.we && bus_cmd.addr == 16'h0017)
			&& tx_data == $past(bus_cmd.wdata);
	endproperty
	a_tx: assert property (p_tx) else $error("transmit load wrong");
	property p_lob;
		bus_ready && $past(bus_req && !bus_cmd.we && bus_cmd.addr == 16'h001c)
			|-> clr_flag_b && bus_rdata == $past(cnt_b_val[7:0]);
	endproperty
	a_lob: assert property (p_lob) else $error("counter b read wrong");
	property p_loa;
		bus_ready && $past(bus_req && !bus_cmd.we && bus_cmd.addr == 16'h0018)
			|-> clr_flag_a && bus_rdata == $past(cnt_a_val[7:0]);
	endproperty
	a_loa: assert property (p_loa) else $error("counter a read wrong");
	property p_load;
		bus_ready && $past(bus_req && bus_cmd.we && bus_cmd.addr == 16'h001e)
			|-> clr_flag_b && cnt_cmd == {4'hf, $past(bus_cmd.wdata)};
	endproperty
	a_load: assert property (p_load) else $error("latch b load wrong");
	// ==========================================
	// pin functions of ports c and d
	property p_short;
		mode_ctrl[7] && mode_ctrl[5] && bus_req && pin_out.c[7] |-> pin_oe.c == 8'hff
			&& pin_out.c[6:0] == {bus_cmd.addr[13], !bus_cmd.we, bus_cmd.addr[12],
			bus_cmd.addr[3:0]} && (!bus_cmd.we || pin_out.d == bus_cmd.wdata);
	endproperty
	a_short: assert property (p_short) else $error("bus pins wrong");
	property p_mux;
		mode_ctrl[7:5] == 3'h7 && $rose(pin_out.c[7])
			|-> $past(pin_out.d) == bus_cmd.addr[11:4] && $past(pin_oe.d) == 8'hff;
	endproperty
	a_mux: assert property (p_mux) else $error("mux address wrong");
	property p_full;
		mode_ctrl[7] && !mode_ctrl[5] |-> pin_oe.c[7:6] == 2'h3;
	endproperty
	a_full: assert property (p_full) else $error("high address undriven");
endmodule

bind iorm_io_decode iorm_io_decode_properties #(.PHASE_CYC(PHASE_CYC))
	i_iorm_io_decode_properties (.*);
`default_nettype wire

//--- verification/iorm_ext_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// external byte memory on the expansion pins
module iorm_ext_mem (
	input  wire logic       ref_clk,
	input  wire logic [7:0] c_out,
	input  wire logic [7:0] c_oe,
	input  wire logic [7:0] d_out,
	input  wire logic [7:0] d_oe,
	output logic [7:0]      d_in
);
	logic [7:0] mem_q [64];
	logic [7:0] last_q = 8'h00;
	// partial decode: only a13, a12 and a3..a0 reach the array
	wire logic [5:0] idx = {c_out[6], c_out[4], c_out[3:0]};
	wire logic       rd_en = c_oe[5] & c_out[5] & ~|d_oe;
	// d has no pull-up: a released bus toggles so stale data never matches
	assign d_in = rd_en ? mem_q[idx] : ~last_q;
	// store while the strobe is high in a write cycle
	always @(posedge ref_clk) begin
		last_q <= d_in;
		if (c_oe[7] & c_out[7] & ~c_out[5])
			mem_q[idx] <= d_out;
	end
endmodule
`default_nettype wire

//--- verification/iorm_io_decode_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module iorm_io_decode_tb_top;
	// ==========================================
	// design inputs and outputs
	logic                    ref_clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic                    bus_req = 1'b0;
	iorm_pkg::iorm_req_t     bus_cmd = '0;
	logic [3:0]              edge_evt = 4'h0;
	logic [3:0]              flag_hi_in = 4'h0;
	logic [15:0]             cnt_a_val = 16'h1234;
	logic [15:0]             cnt_b_val = 16'h5678;
	logic [7:0]              rx_data = 8'h3c;
	logic [7:0]              ser_status_in = 8'h00;
	logic [7:0]              ext_a = 8'hff;
	iorm_pkg::iorm_port_t    pin_in, pin_out, pin_oe;
	iorm_pkg::iorm_cnt_cmd_t cnt_cmd;
	logic bus_ready, clr_flag_a, clr_flag_b, rx_taken, tx_load;
	logic [7:0] bus_rdata, tx_data, ser_ctrl, mode_ctrl, int_enable, int_flags, mem_d, v;
	logic [3:0] strb;
	int tests_run = 0;
	int miscompares = 0;
	logic [15:0] ra [10] = '{16'h0018, 16'h001b, 16'h001a, 16'h001c, 16'h001f, 16'h001e,
		16'h0010, 16'h0019, 16'h0005, 16'h0017};
	logic [7:0] re [10] = '{8'h34, 8'h34, 8'h12, 8'h78, 8'h78, 8'h56, 8'hff, 8'hff, 8'hff,
		8'h3c};
	logic [3:0] rs [10] = '{4'h8, 4'h0, 4'h0, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
	always #2 ref_clk = ~ref_clk;
	// released lines: ext_a on a, pull-ups on b and c, memory model on d
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & {mem_d, 16'hffff, ext_a});
	// longer phases leave room for the three-flop input lag
	iorm_io_decode #(.PHASE_CYC(6)) i_iorm_io_decode (.*);
	iorm_ext_mem i_iorm_ext_mem (.ref_clk, .c_out(pin_out.c), .c_oe(pin_oe.c),
		.d_out(pin_out.d), .d_oe(pin_oe.d), .d_in(mem_d));
	// ==========================================
	// transfer and compare tasks
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// request held until ready is sampled high, then one idle edge
	task automatic acc(input logic w, input logic [15:0] ad, input logic [7:0] wd);
		int n;
		n = 0;
		bus_req <= 1'b1;
		bus_cmd <= '{we: w, addr: ad, wdata: wd};
		do begin
			@(posedge ref_clk);
			n++;
		end while (bus_ready !== 1'b1 && n < 40);
		if (n >= 40)
			miscompares++;
		v = bus_rdata;
		strb = {clr_flag_a, clr_flag_b, rx_taken, tx_load};
		bus_req <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [15:0] ad, input logic [7:0] wd);
		acc(1'b1, ad, wd);
	endtask
	task automatic rd(input logic [15:0] ad, input logic [7:0] exp);
		acc(1'b0, ad, 8'h00);
		chk("read data", v, exp);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================
	// test sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			rd(16'(i), 8'hff);
			wr(16'(i), 8'h5a ^ 8'(i));
			repeat (4) @(posedge ref_clk);
			rd(16'(i), 8'h5a ^ 8'(i));
		end
		wr(16'h0000, 8'hff);
		ext_a <= 8'hc3;
		repeat (4) @(posedge ref_clk);
		rd(16'h0000, 8'hc3);
		foreach (ra[k]) begin
			rd(ra[k], re[k]);
			chk("side strobes", {4'h0, strb}, {4'h0, rs[k]});
		end
		wr(16'h001e, 8'h9a);
		chk("side strobes", {4'h0, strb}, 8'h04);
		wr(16'h0017, 8'ha5);
		chk("side strobes", {4'h0, strb}, 8'h01);
		chk("transmit byte", tx_data, 8'ha5);
		for (int i = 16'h13; i < 16'h16; i += 2) begin
			rd(16'(i), 8'h00);
			wr(16'(i), 8'h69);
			rd(16'(i), 8'h69);
		end
		chk("enable out", int_enable, 8'h69);
		chk("serial control out", ser_ctrl, 8'h69);
		flag_hi_in <= 4'ha;
		edge_evt <= 4'hf;
		@(posedge ref_clk);
		edge_evt <= 4'h0;
		rd(16'h0012, 8'haf);
		wr(16'h0012, 8'hf5);
		rd(16'h0012, 8'ha5);
		chk("flags out", int_flags, 8'ha5);
		ser_status_in <= 8'h8a;
		wr(16'h0016, 8'hff);
		rd(16'h0016, 8'hba);
		wr(16'h0016, 8'h10);
		rd(16'h0016, 8'h9a);
		wr(16'h0014, 8'h80);
		chk("mode out", mode_ctrl, 8'h80);
		wr(16'h0002, 8'h15);
		rd(16'h4000, 8'hff);
		chk("port c pins", pin_in.c, 8'h95);
		wr(16'h0014, 8'ha0);
		wr(16'h0005, 8'h77);
		wr(16'h3012, 8'h3c);
		rd(16'h0005, 8'h77);
		rd(16'h3012, 8'h3c);
		wr(16'h0014, 8'he0);
		wr(16'h0ab7, 8'hd2);
		rd(16'h0ab7, 8'hd2);
		complete_run;
	end
	// hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		complete_run;
	end
endmodule
`default_nettype wire
